// ===== hdl/dual_parallel_output_ports.sv
// Dual 16-bit parallel output ports: direct path and buffered data-set path.
// Assumes sample inputs are synchronous to mclk (the processing clock) and
// that lane enables and item select come from outside and are resynchronised.
`timescale 1ns/1ps
`default_nettype none
module dual_parallel_output_ports (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [15:0] sample_inphase,
    input wire logic [15:0] sample_quad,
    input wire logic [15:0] sample_mag,
    input wire logic [15:0] sample_phase,
    input wire logic [15:0] sample_freq,
    input wire logic [1:0] direct_a_select,
    input wire logic [1:0] direct_b_select,
    input wire logic b_low_direct,
    input wire logic buffer_advance,
    input wire logic [2:0] item_select,
    input wire logic bus_a_high_lane_enable_n,
    input wire logic bus_a_low_lane_enable_n,
    input wire logic bus_b_high_lane_enable_n,
    input wire logic bus_b_low_lane_enable_n,
    output logic [15:0] parallel_bus_a,
    output logic [15:0] parallel_bus_b,
    output logic [15:0] parallel_bus_a_oe,
    output logic [15:0] parallel_bus_b_oe,
    output logic direct_new_data_strobe,
    output logic buffer_ready_irq_n,
    output logic buffer_full,
    output logic [2:0] set_count
);
    // ------------------------------------------------------------
    // Format conversion
    // ------------------------------------------------------------
    logic [15:0] mag_fmt;
    assign mag_fmt = {1'b0, sample_mag[14:0]};

    // ------------------------------------------------------------
    // Direct path selection
    // ------------------------------------------------------------
    logic [15:0] next_direct_a;
    logic [15:0] next_direct_b;
    logic [15:0] direct_a;
    logic [15:0] direct_b;

    always_comb begin
        case (direct_a_select)
            parallel_out_pkg::SRC_A_INPHASE: next_direct_a = sample_inphase;
            parallel_out_pkg::SRC_A_MAG: next_direct_a = mag_fmt;
            parallel_out_pkg::SRC_A_FREQ: next_direct_a = sample_freq;
            default: next_direct_a = sample_inphase;
        endcase
        case (direct_b_select)
            parallel_out_pkg::SRC_B_QUAD: next_direct_b = sample_quad;
            parallel_out_pkg::SRC_B_PHASE: next_direct_b = sample_phase;
            parallel_out_pkg::SRC_B_MAG: next_direct_b = mag_fmt;
            default: next_direct_b = sample_quad;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            direct_a <= parallel_out_pkg::WORD_RESET;
            direct_b <= parallel_out_pkg::WORD_RESET;
        end else if (sample_valid) begin
            direct_a <= next_direct_a;
            direct_b <= next_direct_b;
        end
    end

    // Strobe low in the first cycle the new word is on the bus
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            direct_new_data_strobe <= 1'b1;
        end else begin
            direct_new_data_strobe <= !sample_valid;
        end
    end

    // ------------------------------------------------------------
    // Pin input synchronisers (three stages, second and third agree)
    // ------------------------------------------------------------
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic [6:0] pin_s3;
    logic [6:0] pin_val;
    logic adv_prev;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= 7'h0F;
            pin_s2 <= 7'h0F;
            pin_s3 <= 7'h0F;
            pin_val <= 7'h0F;
        end else begin
            pin_s1 <= {item_select, bus_a_high_lane_enable_n, bus_a_low_lane_enable_n,
                       bus_b_high_lane_enable_n, bus_b_low_lane_enable_n};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int i = 0; i < 7; i++) begin
                if (pin_s2[i] == pin_s3[i]) begin
                    pin_val[i] <= pin_s3[i];
                end
            end
        end
    end

    logic [2:0] item_sel;
    logic a_hi_en_n;
    logic a_lo_en_n;
    logic b_hi_en_n;
    logic b_lo_en_n;
    assign item_sel = pin_val[6:4];
    assign a_hi_en_n = pin_val[3];
    assign a_lo_en_n = pin_val[2];
    assign b_hi_en_n = pin_val[1];
    assign b_lo_en_n = pin_val[0];

    // ------------------------------------------------------------
    // Buffered data-set store
    // ------------------------------------------------------------
    // Flip-flop storage; a full store drops new sets rather than overwrite unread ones
    logic [15:0] store [parallel_out_pkg::SET_DEPTH][parallel_out_pkg::ITEM_COUNT];
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic do_push;
    logic do_pop;
    logic was_empty;

    // Pop on the rising edge only, so a held advance takes one set
    assign do_push = sample_valid && (set_count != 3'(parallel_out_pkg::SET_DEPTH));
    assign do_pop = buffer_advance && !adv_prev && (set_count != 3'h0);
    assign buffer_full = (set_count == 3'(parallel_out_pkg::SET_DEPTH));
    assign was_empty = (set_count == 3'h0);

    function automatic logic [2:0] ptr_inc(input logic [2:0] p);
        ptr_inc = (p == 3'(parallel_out_pkg::SET_DEPTH - 1)) ? 3'h0 : p + 3'h1;
    endfunction

    always_ff @(posedge mclk) begin
        if (do_push) begin
            store[wr_ptr][parallel_out_pkg::ITEM_INPHASE] <= sample_inphase;
            store[wr_ptr][parallel_out_pkg::ITEM_QUAD] <= sample_quad;
            store[wr_ptr][parallel_out_pkg::ITEM_MAG] <= mag_fmt;
            store[wr_ptr][parallel_out_pkg::ITEM_PHASE] <= sample_phase;
            store[wr_ptr][parallel_out_pkg::ITEM_FREQ] <= sample_freq;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            set_count <= 3'h0;
            adv_prev <= 1'b0;
        end else begin
            adv_prev <= buffer_advance;
            if (do_push) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (do_pop) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            case ({do_push, do_pop})
                2'b10: set_count <= set_count + 3'h1;
                2'b01: set_count <= set_count - 3'h1;
                default: set_count <= set_count;
            endcase
        end
    end

    // Ready interrupt: eight cycles low when a set first becomes available
    // A refill right after emptying restarts the full eight cycles
    logic [3:0] irq_cnt;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_cnt <= 4'h0;
        end else if (do_push && was_empty) begin
            irq_cnt <= parallel_out_pkg::IRQ_CNT_LOAD;
        end else if (irq_cnt != 4'h0) begin
            irq_cnt <= irq_cnt - 4'h1;
        end
    end
    assign buffer_ready_irq_n = (irq_cnt == 4'h0);

    // ------------------------------------------------------------
    // Bus assembly and lane enables
    // ------------------------------------------------------------
    // Registered: low bytes follow a new select or pop one cycle later
    logic [15:0] next_buf_word;
    logic [15:0] buf_word;
    always_comb begin
        if (was_empty || item_sel >= 3'(parallel_out_pkg::ITEM_COUNT)) begin
            next_buf_word = parallel_out_pkg::WORD_RESET;
        end else begin
            next_buf_word = store[rd_ptr][item_sel];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            buf_word <= parallel_out_pkg::WORD_RESET;
        end else begin
            buf_word <= next_buf_word;
        end
    end

    // Drive enables only; the three-state pads sit outside this block
    assign parallel_bus_a = {direct_a[15:8], buf_word[15:8]};
    assign parallel_bus_b = {direct_b[15:8], b_low_direct ? direct_b[7:0] : buf_word[7:0]};
    assign parallel_bus_a_oe = {{8{!a_hi_en_n}}, {8{!a_lo_en_n}}};
    assign parallel_bus_b_oe = {{8{!b_hi_en_n}}, {8{!b_lo_en_n}}};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_strobe_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
        !direct_new_data_strobe && !sample_valid |=> direct_new_data_strobe)
        else $error("new-data strobe longer than the data update");
    a_strobe_follows_sample: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_valid |=> !direct_new_data_strobe && direct_a == $past(next_direct_a))
        else $error("direct word or strobe missing after sample");
    a_high_byte_a: assert property (@(posedge mclk) disable iff (!rst_n)
        parallel_bus_a[15:8] == direct_a[15:8])
        else $error("bus A high byte not direct data");
    a_mag_msb_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        sample_valid && direct_a_select == parallel_out_pkg::SRC_A_MAG |=> !parallel_bus_a[15])
        else $error("magnitude MSB not zero");
    a_store_limit: assert property (@(posedge mclk) disable iff (!rst_n)
        set_count <= 3'(parallel_out_pkg::SET_DEPTH))
        else $error("store holds more than seven sets");
    a_irq_eight_low: assert property (@(posedge mclk) disable iff (!rst_n)
        do_push && was_empty |=> !buffer_ready_irq_n [*8])
        else $error("ready interrupt not eight cycles");
    a_irq_release: assert property (@(posedge mclk) disable iff (!rst_n)
        irq_cnt == 4'h1 && !(do_push && was_empty) |=> buffer_ready_irq_n)
        else $error("ready interrupt held past eight cycles");
    a_b_low_direct: assert property (@(posedge mclk) disable iff (!rst_n)
        b_low_direct |-> parallel_bus_b[7:0] == direct_b[7:0])
        else $error("bus B low byte not direct");
    a_lane_release: assert property (@(posedge mclk) disable iff (!rst_n)
        a_lo_en_n |-> parallel_bus_a_oe[7:0] == 8'h00)
        else $error("bus A low lane driven while disabled");
    a_count_tracks: assert property (@(posedge mclk) disable iff (!rst_n)
        do_push && !do_pop |=> set_count == $past(set_count) + 3'h1)
        else $error("set count did not advance on push");
    a_pop_count: assert property (@(posedge mclk) disable iff (!rst_n)
        do_pop && !do_push |=> set_count == $past(set_count) - 3'h1)
        else $error("set count did not drop on pop");
    a_full_drops: assert property (@(posedge mclk) disable iff (!rst_n)
        buffer_full && sample_valid && !do_pop |=> buffer_full && wr_ptr == $past(wr_ptr))
        else $error("full store accepted another set");
    a_strobe_after_sample: assert property (@(posedge mclk) disable iff (!rst_n)
        !direct_new_data_strobe |-> $past(sample_valid))
        else $error("new-data strobe without a sample");
    a_direct_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !sample_valid |=> $stable(direct_a) && $stable(direct_b))
        else $error("direct word changed without a sample");
    a_high_byte_b: assert property (@(posedge mclk) disable iff (!rst_n)
        parallel_bus_b[15:8] == direct_b[15:8])
        else $error("bus B high byte not direct data");
    a_buf_low_bytes: assert property (@(posedge mclk) disable iff (!rst_n)
        !b_low_direct |->
            parallel_bus_a[7:0] == buf_word[15:8] && parallel_bus_b[7:0] == buf_word[7:0])
        else $error("low bytes not the buffered word");
    a_empty_reads_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        was_empty |=> buf_word == parallel_out_pkg::WORD_RESET)
        else $error("empty store read not zero");
    a_item_range: assert property (@(posedge mclk) disable iff (!rst_n)
        item_sel >= 3'(parallel_out_pkg::ITEM_COUNT) |=>
            buf_word == parallel_out_pkg::WORD_RESET)
        else $error("unused item select not zero");
    a_lane_b_release: assert property (@(posedge mclk) disable iff (!rst_n)
        b_hi_en_n |-> parallel_bus_b_oe[15:8] == 8'h00)
        else $error("bus B high lane driven while disabled");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_back_to_back: cover property (@(posedge mclk) disable iff (!rst_n)
        sample_valid ##1 sample_valid);
    c_direct_update: cover property (@(posedge mclk) disable iff (!rst_n)
        sample_valid ##1 !direct_new_data_strobe);
    c_store_full: cover property (@(posedge mclk) disable iff (!rst_n) buffer_full);
    c_pop_set: cover property (@(posedge mclk) disable iff (!rst_n) do_pop);
    c_irq_fire: cover property (@(posedge mclk) disable iff (!rst_n)
        $fell(buffer_ready_irq_n));
endmodule
`default_nettype wire

// ===== hdl/parallel_out_pkg.sv
// Constants for the dual parallel output ports.
// Assumes a single processing clock domain (mclk).
package parallel_out_pkg;
    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int SET_DEPTH = 7;
    localparam int PTR_W = 3;
    localparam int ITEM_COUNT = 5;
    localparam int IRQ_CYCLES = 8;
    localparam logic [3:0] IRQ_CNT_LOAD = 4'h8;
    // ------------------------------------------------------------
    // Direct source selections and item codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_A_INPHASE = 2'h0;
    localparam logic [1:0] SRC_A_MAG = 2'h1;
    localparam logic [1:0] SRC_A_FREQ = 2'h2;
    localparam logic [1:0] SRC_B_QUAD = 2'h0;
    localparam logic [1:0] SRC_B_PHASE = 2'h1;
    localparam logic [1:0] SRC_B_MAG = 2'h2;
    localparam logic [2:0] ITEM_INPHASE = 3'h0;
    localparam logic [2:0] ITEM_QUAD = 3'h1;
    localparam logic [2:0] ITEM_MAG = 3'h2;
    localparam logic [2:0] ITEM_PHASE = 3'h3;
    localparam logic [2:0] ITEM_FREQ = 3'h4;
    localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// ===== test/bus_reader_model.sv
// Reader-side model of the two parallel output buses.
// Assumes per-bit drive enables from the port block and no pull resistors.
`timescale 1ns/1ps
`default_nettype none
module bus_reader_model (
    input wire logic mclk,
    input wire logic [15:0] drive_a,
    input wire logic [15:0] drive_b,
    input wire logic [15:0] oe_a,
    input wire logic [15:0] oe_b,
    output logic [15:0] seen_a,
    output logic [15:0] seen_b
);
    logic [15:0] last_a;
    logic [15:0] last_b;
    // Released bits flip every cycle, so a stale value can never pass
    assign seen_a = (drive_a & oe_a) | (~last_a & ~oe_a);
    assign seen_b = (drive_b & oe_b) | (~last_b & ~oe_b);
    always_ff @(posedge mclk) begin
        last_a <= seen_a;
        last_b <= seen_b;
    end
endmodule
`default_nettype wire

// ===== test/test_dual_parallel_output_ports.sv
// Self-checking bench for the dual parallel output ports.
// Assumes the reader model resolves the bus wires from the drive enables.
`timescale 1ns/1ps
`default_nettype none
module test_dual_parallel_output_ports;
    int errors = 0;
    int total_checks = 0;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sample_valid = 1'b0;
    logic [15:0] smp [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [1:0] a_sel = 2'h0;
    logic [1:0] b_sel = 2'h0;
    logic b_low_direct = 1'b0;
    logic buffer_advance = 1'b0;
    logic [2:0] item_select = 3'h0;
    logic [3:0] lane_n = 4'h0;
    logic [15:0] bus_a, bus_b, oe_a, oe_b, seen_a, seen_b;
    logic strobe, irq_n, full;
    logic [2:0] set_count;
    int a_item [3] = '{0, 2, 4};
    int b_item [3] = '{1, 3, 2};

    dual_parallel_output_ports u_dut (.mclk(mclk), .rst_n(rst_n), .sample_valid(sample_valid),
        .sample_inphase(smp[0]), .sample_quad(smp[1]), .sample_mag(smp[2]),
        .sample_phase(smp[3]), .sample_freq(smp[4]), .direct_a_select(a_sel),
        .direct_b_select(b_sel), .b_low_direct(b_low_direct), .buffer_advance(buffer_advance),
        .item_select(item_select), .bus_a_high_lane_enable_n(lane_n[3]),
        .bus_a_low_lane_enable_n(lane_n[2]), .bus_b_high_lane_enable_n(lane_n[1]),
        .bus_b_low_lane_enable_n(lane_n[0]), .parallel_bus_a(bus_a), .parallel_bus_b(bus_b),
        .parallel_bus_a_oe(oe_a), .parallel_bus_b_oe(oe_b), .direct_new_data_strobe(strobe),
        .buffer_ready_irq_n(irq_n), .buffer_full(full), .set_count(set_count));

    bus_reader_model u_reader (.mclk(mclk), .drive_a(bus_a), .drive_b(bus_b), .oe_a(oe_a),
        .oe_b(oe_b), .seen_a(seen_a), .seen_b(seen_b));

    initial begin
        forever #25 mclk = ~mclk;
    end

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    function automatic logic [15:0] word(int k, int i);
        return {4'hA, 1'b0, i[2:0], k[3:0], 4'h5};
    endfunction
    // Magnitude leaves the port with its top bit cleared
    function automatic logic [15:0] ex(int k, int i);
        return (i == 2) ? (word(k, i) & 16'h7FFF) : word(k, i);
    endfunction
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic push(input int k, input int s);
        @(posedge mclk);
        for (int i = 0; i < 5; i++) smp[i] <= word(k, i);
        a_sel <= s[1:0];
        b_sel <= s[1:0];
        sample_valid <= 1'b1;
        @(posedge mclk);
        sample_valid <= 1'b0;
        #1;
    endtask
    task automatic pop();
        @(posedge mclk);
        buffer_advance <= 1'b1;
        @(posedge mclk);
        buffer_advance <= 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic read_item(input int k, input int i);
        @(posedge mclk);
        item_select <= i[2:0];
        repeat (6) @(posedge mclk);
        #1;
        chk("buffered word", (i < 5) ? ex(k, i) : 16'h0000, {seen_a[7:0], seen_b[7:0]});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic direct_sources();
        for (int s = 0; s < 3; s++) begin
            push(s, s);
            chk("strobe low", 16'h0000, {15'h0000, strobe});
            chk("a high", ex(s, a_item[s]) >> 8, {8'h00, seen_a[15:8]});
            chk("b high", ex(s, b_item[s]) >> 8, {8'h00, seen_b[15:8]});
            if (s == 0) begin
                repeat (7) @(posedge mclk);
                #1;
                chk("irq held", 16'h0000, {15'h0000, irq_n});
                @(posedge mclk);
                #1;
                chk("irq ends", 16'h0001, {15'h0000, irq_n});
            end else begin
                @(posedge mclk);
                #1;
                chk("strobe one cycle", 16'h0001, {15'h0000, strobe});
            end
        end
    endtask
    task automatic buffered_read();
        for (int i = 0; i < 6; i++) read_item(0, i);
        pop();
        read_item(1, 0);
        chk("count", 16'h0002, {13'h0000, set_count});
    endtask
    task automatic b_low_from_direct();
        @(posedge mclk);
        b_low_direct <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        chk("b low direct", ex(2, 2) & 16'h00FF, {8'h00, seen_b[7:0]});
        @(posedge mclk);
        b_low_direct <= 1'b0;
    endtask
    task automatic fill_and_drop();
        for (int k = 3; k < 9; k++) push(k, 0);
        chk("count full", 16'h0007, {13'h0000, set_count});
        chk("full flag", 16'h0001, {15'h0000, full});
        for (int p = 0; p < 6; p++) pop();
        read_item(7, 4);
    endtask
    task automatic lane_release();
        @(posedge mclk);
        lane_n <= 4'hA;
        repeat (6) @(posedge mclk);
        #1;
        chk("oe a", 16'h00FF, oe_a);
        chk("oe b", 16'h00FF, oe_b);
        @(posedge mclk);
        lane_n <= 4'h0;
    endtask

    task automatic final_report();
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // Lane enables need four edges through the pin synchronisers
        repeat (4) @(posedge mclk);
        direct_sources();
        buffered_read();
        b_low_from_direct();
        fill_and_drop();
        lane_release();
        final_report();
    end

    // Whole run needs about 140 cycles
    initial begin
        repeat (3000) @(posedge mclk);
        errors++;
        final_report();
    end
endmodule
`default_nettype wire
